// ### src/rcg_pkg.sv
/*
  Shared constants for the residual check and power-good block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package rcg_pkg;
  // Rail counts
  localparam int unsigned NUM_BUCK = 4;
  localparam int unsigned NUM_EXT = 2;
  localparam int unsigned NUM_RV = NUM_BUCK + NUM_EXT;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RAIL_EN = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SET_BASE = 8'h10;

  // Control register fields
  localparam int unsigned CTL_WINDOW = 0;
  localparam int unsigned CTL_POLARITY = 1;
  localparam int unsigned CTL_OPEN_DRAIN = 2;
  localparam int unsigned CTL_GATE_MCU = 3;
  localparam int unsigned CTL_GATE_SOC = 4;
  localparam int unsigned CTL_INC_ANALOG = 5;
  localparam int unsigned CTL_ANALOG_EN = 6;
  localparam int unsigned CTL_ANALOG_LVL = 7;
  localparam int unsigned CTL_THERM_MASK = 8;
  localparam int unsigned CTL_WIDTH = 9;

  // Rail enable register fields
  localparam int unsigned REN_MON = 0;
  localparam int unsigned REN_REG = 4;
  localparam int unsigned REN_RVSEL = 8;
  localparam int unsigned REN_CURSEL = 12;
  localparam int unsigned REN_EXT_EN = 16;
  localparam int unsigned REN_EXT_RVSEL = 18;
  localparam int unsigned REN_WIDTH = 20;

  // Status register fields
  localparam int unsigned STA_GOOD = 0;
  localparam int unsigned STA_PHASE = 1;
  localparam int unsigned STA_BOOT_HOLD = 2;
  localparam int unsigned STA_ANALOG_ACT = 3;
  localparam int unsigned STA_BUSY = 8;

  // Reset values
  localparam logic [CTL_WIDTH-1:0] CTRL_RST = 9'h001;
  localparam logic [REN_WIDTH-1:0] RAIL_EN_RST = 20'hF_0F0F;
  localparam logic [7:0] VSET_RST = 8'h64;
  localparam logic [7:0] SLEW_RST = 8'h01;

  // Timing
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned RV_MARGIN_US = 100;
  localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned VSET_LSB_MV = 10;
  localparam int unsigned TMO_WIDTH = 16;
endpackage

// ### src/rcg_rv_if.sv
/*
  Carrier between the main block and one residual timeout timer.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface rcg_rv_if;
  logic armed;
  logic mon_en;
  logic above;
  logic [15:0] timeout_us;
  logic busy;
  logic fail;
  modport ctrl (output armed, output mon_en, output above, output timeout_us,
    input busy, input fail);
  modport timer (input armed, input mon_en, input above, input timeout_us,
    output busy, output fail);
endinterface // rcg_rv_if

// ### src/rcg_sync.sv
/*
  Three-stage synchroniser for a vector of comparator levels. A new level
  is accepted once the second and third stages agree.
  Assumes asynchronous inputs and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module rcg_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  initial begin
    if (WIDTH < 1) $error("rcg_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change only when stages two and three agree
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) sync_o[i] <= s3_r[i];
      end
    end
  end
endmodule // rcg_sync

// ### src/rcg_rv_timer.sv
/*
  Residual timeout timer for one rail. Keeps the monitor powered after its
  monitoring is switched off and checks the residual comparator on expiry.
  Assumes a one-cycle microsecond tick and synchronised comparator input.
*/
`timescale 1ns/1ps
module rcg_rv_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Timebase
  input wire logic us_tick_i,
  // Control
  rcg_rv_if.timer rv
);
  logic mon_en_d_r;
  logic busy_r;
  logic fail_r;
  logic [15:0] cnt_r;

  assign rv.busy = busy_r;
  assign rv.fail = fail_r;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) mon_en_d_r <= 1'b0;
    else mon_en_d_r <= rv.mon_en;
  end

  // Timeout runs from monitor switch-off while residual checking is armed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      fail_r <= 1'b0;
    end else begin
      fail_r <= 1'b0;
      if (!rv.armed || rv.mon_en) begin
        busy_r <= 1'b0;
      end else if (mon_en_d_r) begin
        busy_r <= 1'b1;
        cnt_r <= rv.timeout_us;
      end else if (busy_r && us_tick_i) begin
        if (cnt_r <= 16'h0001) begin
          busy_r <= 1'b0;
          fail_r <= rv.above;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule // rcg_rv_timer

// ### src/rcg_top.sv
/*
  Residual voltage check and power-good generation, with a classic
  Wishbone register slave.
  Assumes comparator levels are asynchronous; sequencer and reset outputs
  share the core clock.
*/
// Contract
// - Hold rail ramp and boot self-test entry while residual voltage is high.
// - Residual check needs monitor enable plus residual select per rail or input.
// - Keep a rail monitor powered for the residual timeout after monitoring stops.
// - On timeout, set the rail residual interrupt if voltage still above threshold.
// - Timeout is voltage setting over slew setting plus 100 us.
// - Residual monitoring is enabled once, right after power-up.
// - All residual monitors are disabled before the buck start-up sequence.
// - Per-rail select chooses voltage plus current or voltage-only power-good.
// - Current mode needs window and no current limit; voltage mode ignores limit. Code checks overvoltage in either mode only when the window bit is set.
// - Unmasked thermal warning joins the power-good result.
// - Power-good follows present indications, no latching.
// - Monitor enable enables voltage comparators; regulator enable enables current limit.
// - Current limit counts toward power-good only with monitor enable set.
// - Monitor enable without regulator enable watches the external feedback rail.
// - Disabled buck monitors are masked out of power-good.
// - Analog supply monitor runs from its enable, after self-test passes.
// - One bit selects the analog supply reference level.
// - Analog supply result joins power-good only when selected.
// - Reset outputs gate power-good when their gating bits are set.
// - Power-good is the AND of all included sources.
// - Window bit: 0 checks undervoltage only, 1 checks both.
// - Polarity bit and output-type bit shape the power-good pin.
`timescale 1ns/1ps
module rcg_top
  import rcg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous comparator levels
  input wire logic [NUM_BUCK-1:0] rail_uv_i,
  input wire logic [NUM_BUCK-1:0] rail_ov_i,
  input wire logic [NUM_BUCK-1:0] rail_residual_above_i,
  input wire logic [NUM_BUCK-1:0] current_limit_indication_i,
  input wire logic [NUM_EXT-1:0] ext_uv_i,
  input wire logic [NUM_EXT-1:0] ext_ov_i,
  input wire logic [NUM_EXT-1:0] ext_residual_above_i,
  input wire logic analog_supply_uv_i,
  input wire logic analog_supply_ov_i,
  input wire logic thermal_warning_i,
  // Sequencer and reset sources
  input wire logic buck_seq_start_i,
  input wire logic boot_selftest_state_i,
  input wire logic analog_selftest_pass_i,
  input wire logic mcu_reset_output_n_i,
  input wire logic soc_reset_output_n_i,
  // Comparator and ramp control
  output logic [NUM_BUCK-1:0] rail_vcmp_enable_o,
  output logic [NUM_BUCK-1:0] rail_current_limit_indication_enable_o,
  output logic [NUM_BUCK-1:0] rail_external_mode_o,
  output logic [NUM_EXT-1:0] ext_vcmp_enable_o,
  output logic [NUM_BUCK-1:0] rail_ramp_hold_o,
  output logic [NUM_EXT-1:0] ext_ramp_hold_o,
  output logic boot_selftest_hold_o,
  output logic analog_supply_monitor_active_o,
  output logic analog_supply_level_select_o,
  // Power-good pin
  output logic power_good_output_o,
  output logic power_good_output_oe_n_o
);
  localparam int unsigned SYNC_W = 4 * NUM_BUCK + 3 * NUM_EXT + 3;
  localparam logic [5:0] US_DIV_LAST = 6'(CYC_PER_US - 1);

  logic [CTL_WIDTH-1:0] ctrl_r;
  logic [REN_WIDTH-1:0] rail_en_r;
  logic [NUM_RV-1:0] irq_r;
  logic [7:0] vset_r [NUM_RV];
  logic [7:0] slew_r [NUM_RV];
  logic wb_ack_r;
  logic [31:0] rd_dat_r;
  logic rv_phase_r;
  logic [5:0] us_div_r;
  logic us_tick_r;
  logic analog_act_r;
  logic pin_level_r;
  logic pin_oe_n_r;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_q;
  logic [NUM_BUCK-1:0] s_uv;
  logic [NUM_BUCK-1:0] s_ov;
  logic [NUM_BUCK-1:0] s_res;
  logic [NUM_BUCK-1:0] s_current_limit_indication;
  logic [NUM_EXT-1:0] s_ext_uv;
  logic [NUM_EXT-1:0] s_ext_ov;
  logic [NUM_EXT-1:0] s_ext_res;
  logic s_an_uv;
  logic s_an_ov;
  logic s_therm;

  logic [NUM_BUCK-1:0] mon_en;
  logic [NUM_BUCK-1:0] reg_en;
  logic [NUM_BUCK-1:0] cur_sel;
  logic [NUM_EXT-1:0] ext_en;
  logic [NUM_RV-1:0] rv_mon_en;
  logic [NUM_RV-1:0] rv_sel;
  logic [NUM_RV-1:0] rv_armed;
  logic [NUM_RV-1:0] rv_above;
  logic [NUM_RV-1:0] rv_busy;
  logic [NUM_RV-1:0] rv_fail;
  logic [NUM_BUCK-1:0] buck_ok;
  logic [NUM_EXT-1:0] ext_ok;
  logic analog_ok;
  logic therm_ok;
  logic good_raw;
  logic good_gated;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wmask;

  initial begin
    if (CYC_PER_US < 1 || CYC_PER_US > 64) $error("rcg_top: clock rate out of range");
  end

  // Comparator synchronisation
  assign sync_in = {thermal_warning_i, analog_supply_ov_i, analog_supply_uv_i,
    ext_residual_above_i, ext_ov_i, ext_uv_i, current_limit_indication_i,
    rail_residual_above_i, rail_ov_i, rail_uv_i};

  rcg_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(sync_in),
    .sync_o(sync_q)
  );

  assign {s_therm, s_an_ov, s_an_uv, s_ext_res, s_ext_ov, s_ext_uv, s_current_limit_indication, s_res, s_ov,
    s_uv} = sync_q;

  // Field views
  assign mon_en = rail_en_r[REN_MON +: NUM_BUCK];
  assign reg_en = rail_en_r[REN_REG +: NUM_BUCK];
  assign cur_sel = rail_en_r[REN_CURSEL +: NUM_BUCK];
  assign ext_en = rail_en_r[REN_EXT_EN +: NUM_EXT];
  assign rv_mon_en = {ext_en, mon_en};
  assign rv_above = {s_ext_res, s_res};
  assign rv_sel = {rail_en_r[REN_EXT_RVSEL +: NUM_EXT], rail_en_r[REN_RVSEL +: NUM_BUCK]};
  assign rv_armed = rv_mon_en & rv_sel & {NUM_RV{rv_phase_r}};

  // Residual timeout in microseconds
  function automatic logic [15:0] rv_timeout_us(input logic [7:0] vset,
    input logic [7:0] slew);
    logic [15:0] mv;
    logic [15:0] rate;
    mv = 16'(vset) * 16'(VSET_LSB_MV);
    rate = (slew == 8'h00) ? 16'h0001 : 16'(slew);
    return 16'(mv / rate) + 16'(RV_MARGIN_US);
  endfunction

  // Microsecond tick
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      us_div_r <= '0;
      us_tick_r <= 1'b0;
    end else begin
      us_tick_r <= (us_div_r == US_DIV_LAST);
      us_div_r <= (us_div_r == US_DIV_LAST) ? 6'h00 : us_div_r + 6'h01;
    end
  end

  // Residual phase opens at power-up only and closes for the start-up sequence
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) rv_phase_r <= 1'b1;
    else if (buck_seq_start_i) rv_phase_r <= 1'b0;
  end

  // Residual timers
  generate
    for (genvar g = 0; g < NUM_RV; g++) begin : g_rv
      rcg_rv_if rv_bus ();
      // Timer must outlive the monitor enable, so it sees select and phase only
      assign rv_bus.armed = rv_sel[g] && rv_phase_r;
      assign rv_bus.mon_en = rv_mon_en[g];
      assign rv_bus.above = rv_above[g];
      assign rv_bus.timeout_us = rv_timeout_us(vset_r[g], slew_r[g]);
      assign rv_busy[g] = rv_bus.busy;
      assign rv_fail[g] = rv_bus.fail;
      rcg_rv_timer u_timer (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .us_tick_i(us_tick_r),
        .rv(rv_bus.timer)
      );
    end
  endgenerate

  // Ramp and boot holds
  assign rail_ramp_hold_o = rv_armed[NUM_BUCK-1:0] & s_res;
  assign ext_ramp_hold_o = rv_armed[NUM_RV-1:NUM_BUCK] & s_ext_res;
  assign boot_selftest_hold_o = |(rv_armed & rv_above);

  // Comparator enables
  assign rail_vcmp_enable_o = mon_en | rv_busy[NUM_BUCK-1:0];
  assign ext_vcmp_enable_o = ext_en | rv_busy[NUM_RV-1:NUM_BUCK];
  assign rail_current_limit_indication_enable_o = reg_en;
  assign rail_external_mode_o = mon_en & ~reg_en;
  assign analog_supply_level_select_o = ctrl_r[CTL_ANALOG_LVL];
  assign analog_supply_monitor_active_o = analog_act_r;

  // Analog supply monitoring starts once enabled and self-test has passed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) analog_act_r <= 1'b0;
    else if (!ctrl_r[CTL_ANALOG_EN]) analog_act_r <= 1'b0;
    else if (boot_selftest_state_i && analog_selftest_pass_i) analog_act_r <= 1'b1;
  end

  // Power-good sources
  generate
    for (genvar b = 0; b < NUM_BUCK; b++) begin : g_buck_ok
      assign buck_ok[b] = !mon_en[b] ||
        (!s_uv[b] && !(ctrl_r[CTL_WINDOW] && s_ov[b]) &&
        !(cur_sel[b] && s_current_limit_indication[b]));
    end
    for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext_ok
      assign ext_ok[e] = !ext_en[e] ||
        (!s_ext_uv[e] && !(ctrl_r[CTL_WINDOW] && s_ext_ov[e]));
    end
  endgenerate

  assign analog_ok = !(ctrl_r[CTL_INC_ANALOG] && analog_act_r) ||
    (!s_an_uv && !(ctrl_r[CTL_WINDOW] && s_an_ov));
  assign therm_ok = ctrl_r[CTL_THERM_MASK] || !s_therm;
  assign good_raw = (&buck_ok) && (&ext_ok) && analog_ok && therm_ok;
  assign good_gated = good_raw &&
    (!ctrl_r[CTL_GATE_MCU] || mcu_reset_output_n_i) &&
    (!ctrl_r[CTL_GATE_SOC] || soc_reset_output_n_i);

  // Pin stage: follows the present result every cycle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_level_r <= 1'b0;
      pin_oe_n_r <= 1'b0;
    end else begin
      pin_level_r <= ctrl_r[CTL_POLARITY] ? good_gated : !good_gated;
      if (ctrl_r[CTL_OPEN_DRAIN]) begin
        pin_oe_n_r <= ctrl_r[CTL_POLARITY] ? good_gated : !good_gated;
      end else begin
        pin_oe_n_r <= 1'b0;
      end
    end
  end

  assign power_good_output_o = pin_level_r;
  assign power_good_output_oe_n_o = pin_oe_n_r;

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  assign wb_wr = wb_req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) wb_ack_r <= 1'b0;
    else wb_ack_r <= wb_req;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= CTRL_RST;
      rail_en_r <= RAIL_EN_RST;
    end else if (wb_wr && wb_adr_i == OFS_CTRL) begin
      ctrl_r <= CTL_WIDTH'((32'(ctrl_r) & ~wmask) | (wb_dat_i & wmask));
    end else if (wb_wr && wb_adr_i == OFS_RAIL_EN) begin
      rail_en_r <= REN_WIDTH'((32'(rail_en_r) & ~wmask) | (wb_dat_i & wmask));
    end
  end

  // Sticky residual flags, write one to clear; a new failure wins
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_r <= '0;
    end else if (wb_wr && wb_adr_i == OFS_IRQ && wb_sel_i[0]) begin
      irq_r <= (irq_r & ~wb_dat_i[NUM_RV-1:0]) | rv_fail;
    end else begin
      irq_r <= irq_r | rv_fail;
    end
  end

  // Rail settings: low byte voltage, next byte slew
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_RV; i++) begin
        vset_r[i] <= VSET_RST;
        slew_r[i] <= SLEW_RST;
      end
    end else if (wb_wr) begin
      for (int i = 0; i < NUM_RV; i++) begin
        if (wb_adr_i == OFS_SET_BASE + 8'(4 * i)) begin
          if (wb_sel_i[0]) vset_r[i] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) slew_r[i] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_dat_r <= '0;
    end else if (wb_req) begin
      rd_dat_r <= '0;
      case (wb_adr_i)
        OFS_CTRL: rd_dat_r <= 32'(ctrl_r);
        OFS_RAIL_EN: rd_dat_r <= 32'(rail_en_r);
        OFS_IRQ: rd_dat_r <= 32'(irq_r);
        OFS_STATUS: begin
          rd_dat_r[STA_GOOD] <= good_gated;
          rd_dat_r[STA_PHASE] <= rv_phase_r;
          rd_dat_r[STA_BOOT_HOLD] <= boot_selftest_hold_o;
          rd_dat_r[STA_ANALOG_ACT] <= analog_act_r;
          rd_dat_r[STA_BUSY +: NUM_RV] <= rv_busy;
        end
        default: begin
          for (int i = 0; i < NUM_RV; i++) begin
            if (wb_adr_i == OFS_SET_BASE + 8'(4 * i)) rd_dat_r <= {16'h0000, slew_r[i], vset_r[i]};
          end
        end
      endcase
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = rd_dat_r;
endmodule // rcg_top

// ### verification/rcg_checker.sv
/*
  Port-level assertions for rcg_top, with a shadow of the control register.
  Assumes bind below; one clock domain.
*/
`timescale 1ns/1ps
module rcg_checker
  import rcg_pkg::*;
(
  // Clock, reset and bus
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Reset sources
  input wire logic mcu_reset_output_n_i,
  input wire logic soc_reset_output_n_i,
  // Observed outputs
  input wire logic [NUM_BUCK-1:0] rail_vcmp_enable_o,
  input wire logic [NUM_BUCK-1:0] rail_current_limit_indication_enable_o,
  input wire logic [NUM_BUCK-1:0] rail_external_mode_o,
  input wire logic [NUM_BUCK-1:0] rail_ramp_hold_o,
  input wire logic [NUM_EXT-1:0] ext_ramp_hold_o,
  input wire logic boot_selftest_hold_o,
  input wire logic analog_supply_level_select_o,
  input wire logic power_good_output_o,
  input wire logic power_good_output_oe_n_o
);
  logic [CTL_WIDTH-1:0] ctrl_r;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL) begin
      if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_r[8] <= wb_dat_i[8];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_mcu_gated;
    (ctrl_r[CTL_GATE_MCU] && !mcu_reset_output_n_i && $stable(ctrl_r))[*3];
  endsequence
  sequence s_soc_gated;
    (ctrl_r[CTL_GATE_SOC] && !soc_reset_output_n_i && $stable(ctrl_r))[*3];
  endsequence
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_boot_hold_or: assert property (boot_selftest_hold_o == |{rail_ramp_hold_o, ext_ramp_hold_o})
    else $error("boot hold differs from rail holds");
  a_ext_mode_split: assert property ((rail_external_mode_o & rail_current_limit_indication_enable_o) == '0)
    else $error("external mode on an enabled regulator");
  a_ext_mode_vcmp: assert property ((rail_external_mode_o & ~rail_vcmp_enable_o) == '0)
    else $error("external rail without comparators");
  a_level_select: assert property (analog_supply_level_select_o == ctrl_r[CTL_ANALOG_LVL])
    else $error("analog level select differs");
  a_od_release: assert property (ctrl_r[CTL_OPEN_DRAIN] && $past(ctrl_r[CTL_OPEN_DRAIN])
    |-> power_good_output_oe_n_o == power_good_output_o)
    else $error("open-drain pin drives high");
  a_pushpull_drive: assert property (!ctrl_r[CTL_OPEN_DRAIN] && !$past(ctrl_r[CTL_OPEN_DRAIN])
    |-> !power_good_output_oe_n_o)
    else $error("push-pull pin released");
  a_mcu_gate: assert property (s_mcu_gated |-> power_good_output_o == !ctrl_r[CTL_POLARITY])
    else $error("pin not gated by mcu reset");
  a_soc_gate: assert property (s_soc_gated |-> power_good_output_o == !ctrl_r[CTL_POLARITY])
    else $error("pin not gated by soc reset");
endmodule // rcg_checker

bind rcg_top rcg_checker u_chk (.core_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .mcu_reset_output_n_i, .soc_reset_output_n_i,
  .rail_vcmp_enable_o, .rail_current_limit_indication_enable_o, .rail_external_mode_o, .rail_ramp_hold_o,
  .ext_ramp_hold_o, .boot_selftest_hold_o, .analog_supply_level_select_o,
  .power_good_output_o, .power_good_output_oe_n_o);

// ### verification/rcg_pg_listener.sv
/*
  Board side of the power-good pin: a pulled-up net read by a processor.
  Assumes oe_n low while the block drives the pin.
*/
`timescale 1ns/1ps
module rcg_pg_listener (
  // Pin from the block
  input wire logic pin_i,
  input wire logic oe_n_i,
  // Level seen by the processor
  output logic level_o
);
  // A released pin floats up to the pull-up
  assign level_o = oe_n_i ? 1'b1 : pin_i;
endmodule // rcg_pg_listener

// ### verification/tb_top.sv
/*
  Self-checking bench for rcg_top: residual timers, then power-good sources.
  Assumes classic Wishbone single cycles and a pulled-up power-good net.
*/
`timescale 1ns/1ps
module tb_top
  import rcg_pkg::*;
;
  logic core_clk_i = 0, rstn_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic wb_ack_o, boot_selftest_hold_o, analog_supply_monitor_active_o;
  logic analog_supply_level_select_o, power_good_output_o, power_good_output_oe_n_o, pg_lvl;
  logic [3:0] rail_uv_i = '0, rail_ov_i = '0, rail_residual_above_i = '0;
  logic [3:0] current_limit_indication_i = '0;
  logic [3:0] rail_vcmp_enable_o, rail_current_limit_indication_enable_o, rail_external_mode_o, rail_ramp_hold_o;
  logic [1:0] ext_uv_i = '0, ext_ov_i = '0, ext_vcmp_enable_o, ext_ramp_hold_o;
  logic analog_supply_uv_i = 0, thermal_warning_i = 0, buck_seq_start_i = 0;
  logic boot_selftest_state_i = 0, analog_selftest_pass_i = 0;
  logic mcu_reset_output_n_i = 1, soc_reset_output_n_i = 1;
  int n_fail = 0, n_compared = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  rcg_top DUT (.core_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rail_uv_i, .rail_ov_i, .rail_residual_above_i,
    .current_limit_indication_i, .ext_uv_i, .ext_ov_i, .ext_residual_above_i(2'b00),
    .analog_supply_uv_i, .analog_supply_ov_i(1'b0), .thermal_warning_i, .buck_seq_start_i,
    .boot_selftest_state_i, .analog_selftest_pass_i, .mcu_reset_output_n_i,
    .soc_reset_output_n_i, .rail_vcmp_enable_o, .rail_current_limit_indication_enable_o, .rail_external_mode_o,
    .ext_vcmp_enable_o, .rail_ramp_hold_o, .ext_ramp_hold_o, .boot_selftest_hold_o,
    .analog_supply_monitor_active_o, .analog_supply_level_select_o, .power_good_output_o,
    .power_good_output_oe_n_o);

  rcg_pg_listener u_host (.pin_i(power_good_output_o), .oe_n_i(power_good_output_oe_n_o),
    .level_o(pg_lvl));

  task automatic test_done;
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; read data lands in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  // Let synchroniser and pin register settle, then look at the net
  task automatic pg(input logic e);
    repeat (8) @(posedge core_clk_i);
    check({31'b0, pg_lvl}, {31'b0, e});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CTRL, {23'b0, CTRL_RST});
    rd(OFS_RAIL_EN, {12'b0, RAIL_EN_RST});
    rd(OFS_SET_BASE, {16'b0, SLEW_RST, VSET_RST});
    rd(8'h40, 32'h0000_0000);
    pg(1'b0);
    rail_residual_above_i <= 4'h3;
    pg(1'b0);
    check(rail_ramp_hold_o, 4'h3);
    check(boot_selftest_hold_o, 1'b1);
    // Rails 0 and 3 both time out after 110 us
    wr(OFS_SET_BASE, 32'h0000_0A0A);
    wr(OFS_SET_BASE + 8'h0C, 32'h0000_6464);
    wr(OFS_RAIL_EN, 32'h0000_FD04);
    repeat (4000) @(posedge core_clk_i);
    check(rail_vcmp_enable_o, 4'hD);
    rd(OFS_IRQ, 32'h0000_0000);
    repeat (600) @(posedge core_clk_i);
    check(rail_vcmp_enable_o, 4'h4);
    check(rail_ramp_hold_o, 4'h0);
    rd(OFS_IRQ, 32'h0000_0001);
    wr(OFS_IRQ, 32'h0000_0001);
    rd(OFS_IRQ, 32'h0000_0000);
    buck_seq_start_i <= 1'b1;
    rail_residual_above_i <= 4'h4;
    @(posedge core_clk_i);
    buck_seq_start_i <= 1'b0;
    pg(1'b0);
    check(rail_ramp_hold_o, 4'h0);
    check(boot_selftest_hold_o, 1'b0);
    xfer(1'b0, OFS_STATUS, 32'h0000_0000);
    check(q[STA_PHASE], 1'b0);
    wr(OFS_RAIL_EN, 32'h0000_FF1B);
    check(rail_vcmp_enable_o, 4'hB);
    check(rail_current_limit_indication_enable_o, 4'h1);
    check(rail_external_mode_o, 4'hA);
    rail_residual_above_i <= 4'h0;
    wr(OFS_CTRL, 32'h0000_0003);
    pg(1'b1);
    rail_uv_i <= 4'h8;
    pg(1'b0);
    rail_uv_i <= 4'h4;
    pg(1'b1);
    current_limit_indication_i <= 4'h4;
    pg(1'b1);
    current_limit_indication_i <= 4'h1;
    rail_uv_i <= 4'h0;
    pg(1'b0);
    wr(OFS_RAIL_EN, 32'h0000_EF1B);
    pg(1'b1);
    current_limit_indication_i <= 4'h0;
    rail_ov_i <= 4'h1;
    pg(1'b0);
    wr(OFS_CTRL, 32'h0000_0002);
    pg(1'b1);
    rail_ov_i <= 4'h0;
    thermal_warning_i <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0003);
    pg(1'b0);
    wr(OFS_CTRL, 32'h0000_0103);
    pg(1'b1);
    thermal_warning_i <= 1'b0;
    boot_selftest_state_i <= 1'b1;
    analog_selftest_pass_i <= 1'b1;
    wr(OFS_CTRL, 32'h0000_00E3);
    pg(1'b1);
    check(analog_supply_monitor_active_o, 1'b1);
    check(analog_supply_level_select_o, 1'b1);
    analog_supply_uv_i <= 1'b1;
    pg(1'b0);
    wr(OFS_CTRL, 32'h0000_00C3);
    pg(1'b1);
    analog_supply_uv_i <= 1'b0;
    wr(OFS_RAIL_EN, 32'h0001_EF1B);
    check(ext_vcmp_enable_o, 2'h1);
    check(ext_ramp_hold_o, 2'h0);
    ext_uv_i <= 2'h1;
    pg(1'b0);
    ext_uv_i <= 2'h0;
    ext_ov_i <= 2'h1;
    pg(1'b0);
    ext_ov_i <= 2'h0;
    mcu_reset_output_n_i <= 1'b0;
    pg(1'b1);
    wr(OFS_CTRL, 32'h0000_000B);
    pg(1'b0);
    mcu_reset_output_n_i <= 1'b1;
    soc_reset_output_n_i <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0013);
    pg(1'b0);
    soc_reset_output_n_i <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0007);
    pg(1'b1);
    check(power_good_output_oe_n_o, 1'b1);
    rail_uv_i <= 4'h1;
    pg(1'b0);
    check(power_good_output_oe_n_o, 1'b0);
    test_done();
  end
endmodule // tb_top
